// *** i2c_esa_pkg.sv ***
/*
 * Constants and carrier types for the enable, status, level, hold-time
 * and abort-cause register slice of a two-wire bus controller.
 * Assumes the serial engine and queues live elsewhere and report
 * through the status carrier declared here.
 */
package i2c_esa_pkg;

   ////////////////////////////////////////////////////////////////////
   // Register byte offsets on the APB.
   localparam logic [7:0] OFS_TX_ABORT_CLR = 8'h54;
   localparam logic [7:0] OFS_GENERAL_CALL_IRQ_CLR = 8'h68;
   localparam logic [7:0] OFS_ENABLE = 8'h6C;
   localparam logic [7:0] OFS_STATUS = 8'h70;
   localparam logic [7:0] OFS_TX_LEVEL = 8'h74;
   localparam logic [7:0] OFS_RX_LEVEL = 8'h78;
   localparam logic [7:0] OFS_HOLD = 8'h7C;
   localparam logic [7:0] OFS_ABORT_CAUSE = 8'h80;

   ////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int EN_BIT = 0;
   localparam int ABORT_BIT = 1;
   localparam int ST_ACTIVITY = 0;
   localparam int ST_TX_NOT_FULL = 1;
   localparam int ST_TX_EMPTY = 2;
   localparam int ST_RX_NONEMPTY = 3;
   localparam int ST_RX_FULL = 4;
   localparam int ST_INIT_BUSY = 5;
   localparam int ST_TARG_BUSY = 6;
   localparam int CA_SECOND_ADDR = 2;
   localparam int CA_DATA_UNACK = 3;
   localparam int CA_GCALL_UNACK = 4;
   localparam int CA_GCALL_READ = 5;
   localparam int CA_HS_ACKED = 6;
   localparam int CA_SB_ACKED = 7;
   localparam int CA_HS_NORST = 8;
   localparam int CA_SB_NORST = 9;
   localparam int CA_10B_NORST = 10;
   localparam int CA_INIT_DIS = 11;
   localparam int CA_ARB_LOSS = 12;
   localparam int CA_STALE = 13;
   localparam int CA_SLV_LOST = 14;
   localparam int CA_RD_WRITTEN = 15;
   localparam int CA_CANCEL = 16;
   localparam int CA_LO = 2;
   localparam int CA_HI = 16;
   localparam int FLUSH_LSB = 24;
   localparam int CMD_READ_BIT = 8;
   localparam int CMD_GCALL_READ_BIT = 9;

   ////////////////////////////////////////////////////////////////////
   // Reset values and widths.
   localparam logic [15:0] HOLD_RESET = 16'h0001;
   localparam int LEVEL_W = 4;
   localparam int QUEUE_DEPTH = 8;

   // Abort sequencer states, one-hot.
   typedef enum logic [1:0]
   {
      ABT_IDLE = 2'b01,
      ABT_RUN = 2'b10
   } abort_state_t;

   // What the serial engine and queues report each cycle.
   typedef struct packed
   {
      logic general_call_irq_evt;
      logic abort_done;
      logic init_busy;
      logic targ_busy;
      logic bus_active;
      logic [LEVEL_W-1:0] tx_level;
      logic [LEVEL_W-1:0] rx_level;
      logic restart_allow;
      logic init_mode_on;
      logic init_start_req;
      logic tenbit_read_req;
      logic start_byte_req;
      logic highspeed_req;
      logic cmd_write;
      logic [9:0] cmd_word;
      logic targ_rd_pending;
      logic gcall_sent;
      logic targ_read_cmd;
      logic [CA_HI:CA_LO] cause_evt;
   } engine_status_t;

endpackage : i2c_esa_pkg

// *** i2c_esa_regs.sv ***
/*
 * APB register slice: enable and abort control, status, queue levels,
 * data-line hold time, abort cause, and the read-to-clear registers for
 * the general-call and transmit-abort flags.
 * Assumes a zero-wait APB master on CLK and an engine whose status and
 * pulse inputs are synchronous to CLK.
 */
`timescale 1ns/100ps

module i2c_esa_regs
#(
   parameter int TX_DEPTH = i2c_esa_pkg::QUEUE_DEPTH,
   parameter int RX_DEPTH = i2c_esa_pkg::QUEUE_DEPTH
)
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire i2c_esa_pkg::engine_status_t ENGINE,
   output logic CONTROLLER_ON,
   output logic ABORT_REQUEST,
   output logic [15:0] DATA_LINE_HOLD_CYCLES,
   output logic GENERAL_CALL_IRQ,
   output logic TRANSMIT_ABORT_IRQ
);

   ////////////////////////////////////////////////////////////////////
   // Bus decode.
   // A transfer is decoded from the bus inputs alone, with no state of its own.
   // Read data are registered in the setup cycle, so the access cycle only
   // confirms what was already chosen. This keeps the read path off the
   // combinational return path at the cost of one flop stage.

   logic setup_phase;
   logic access_done;
   logic wr_done;
   logic rd_done;
   logic addr_known;
   logic [31:0] read_mux;

   // The slave never inserts wait states, so every access ends on its
   // first access-phase edge.
   assign PREADY = 1'b1;
   assign setup_phase = PSEL & ~PENABLE;
   assign access_done = PSEL & PENABLE;
   assign wr_done = access_done & PWRITE;
   assign rd_done = access_done & ~PWRITE;

   // Unmapped addresses answer with an error and have no effect.
   always_comb
   begin
      case (PADDR)
         i2c_esa_pkg::OFS_TX_ABORT_CLR,
         i2c_esa_pkg::OFS_GENERAL_CALL_IRQ_CLR,
         i2c_esa_pkg::OFS_ENABLE,
         i2c_esa_pkg::OFS_STATUS,
         i2c_esa_pkg::OFS_TX_LEVEL,
         i2c_esa_pkg::OFS_RX_LEVEL,
         i2c_esa_pkg::OFS_HOLD,
         i2c_esa_pkg::OFS_ABORT_CAUSE: addr_known = 1'b1;
         default: addr_known = 1'b0;
      endcase
   end

   // The error answer is combinational, like the ready line, so it stands
   // only in the access cycle. A write to an unknown offset changes nothing.
   assign PSLVERR = access_done & ~addr_known;

   ////////////////////////////////////////////////////////////////////
   // Enable and hold-time registers.

   // Software owns both registers outright; the engine only reads them.
   // The hold time is handed over unchanged, so a value of zero is legal
   // here and it is up to the engine to treat it sensibly.
   logic enable_reg;
   logic [15:0] hold_reg;

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         enable_reg <= 1'b0;
      else if (wr_done && PADDR == i2c_esa_pkg::OFS_ENABLE)
         enable_reg <= PWDATA[i2c_esa_pkg::EN_BIT];
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         hold_reg <= i2c_esa_pkg::HOLD_RESET;
      else if (wr_done && PADDR == i2c_esa_pkg::OFS_HOLD)
         hold_reg <= PWDATA[15:0];
   end

   // The outputs are the registers themselves.
   assign CONTROLLER_ON = enable_reg;
   assign DATA_LINE_HOLD_CYCLES = hold_reg;

   ////////////////////////////////////////////////////////////////////
   // Abort sequencer.
   // The abort bit is a request that the engine acknowledges. It is kept
   // as a two-state sequencer rather than a plain flag so that a second write
   // of one during a running abort cannot restart it, and so that the bit that
   // software reads back is exactly the state that drives the engine.

   i2c_esa_pkg::abort_state_t abort_reg;
   i2c_esa_pkg::abort_state_t abort_next;
   logic abort_write;

   assign abort_write = wr_done && PADDR == i2c_esa_pkg::OFS_ENABLE &&
      PWDATA[i2c_esa_pkg::ABORT_BIT];

   always_comb
   begin
      case (abort_reg)
         i2c_esa_pkg::ABT_IDLE:
            abort_next = abort_write ? i2c_esa_pkg::ABT_RUN : i2c_esa_pkg::ABT_IDLE;
         i2c_esa_pkg::ABT_RUN:
            abort_next = ENGINE.abort_done ? i2c_esa_pkg::ABT_IDLE : i2c_esa_pkg::ABT_RUN;
         default:
            abort_next = i2c_esa_pkg::ABT_IDLE;
      endcase
   end

   // Writing zero never cancels an abort; only the engine ends it.
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         abort_reg <= i2c_esa_pkg::ABT_IDLE;
      else
         abort_reg <= abort_next;
   end

   // The engine winds the transfer down while the sequencer runs.
   assign ABORT_REQUEST = abort_reg == i2c_esa_pkg::ABT_RUN;

   ////////////////////////////////////////////////////////////////////
   // Abort-cause events.
   // Most causes are detected inside the serial engine and arrive as pulses.
   // A few can be judged from what the engine reports about commands and
   // queue levels. Those are derived here so that the engine need not know
   // the register layout. Every cause is a one-cycle pulse.

   logic [i2c_esa_pkg::CA_HI:i2c_esa_pkg::CA_LO] cause_set;

   // Locally derived causes are merged with those the engine reports.
   always_comb
   begin
      cause_set = ENGINE.cause_evt;
      cause_set[i2c_esa_pkg::CA_CANCEL] = ENGINE.cause_evt[i2c_esa_pkg::CA_CANCEL] |
         (ABORT_REQUEST & ENGINE.abort_done);
      cause_set[i2c_esa_pkg::CA_RD_WRITTEN] = ENGINE.cause_evt[i2c_esa_pkg::CA_RD_WRITTEN] |
         (ENGINE.cmd_write & ENGINE.targ_rd_pending &
         ENGINE.cmd_word[i2c_esa_pkg::CMD_READ_BIT]);
      cause_set[i2c_esa_pkg::CA_STALE] = ENGINE.cause_evt[i2c_esa_pkg::CA_STALE] |
         (ENGINE.targ_read_cmd & (ENGINE.tx_level != '0));
      cause_set[i2c_esa_pkg::CA_ARB_LOSS] = ENGINE.cause_evt[i2c_esa_pkg::CA_ARB_LOSS] |
         ENGINE.cause_evt[i2c_esa_pkg::CA_SLV_LOST];
      cause_set[i2c_esa_pkg::CA_INIT_DIS] = ENGINE.cause_evt[i2c_esa_pkg::CA_INIT_DIS] |
         (ENGINE.init_start_req & ~ENGINE.init_mode_on);
      cause_set[i2c_esa_pkg::CA_10B_NORST] = ENGINE.cause_evt[i2c_esa_pkg::CA_10B_NORST] |
         (ENGINE.tenbit_read_req & ~ENGINE.restart_allow);
      cause_set[i2c_esa_pkg::CA_SB_NORST] = ENGINE.cause_evt[i2c_esa_pkg::CA_SB_NORST] |
         (ENGINE.start_byte_req & ~ENGINE.restart_allow);
      cause_set[i2c_esa_pkg::CA_HS_NORST] = ENGINE.cause_evt[i2c_esa_pkg::CA_HS_NORST] |
         (ENGINE.highspeed_req & ~ENGINE.restart_allow);
      cause_set[i2c_esa_pkg::CA_GCALL_READ] = ENGINE.cause_evt[i2c_esa_pkg::CA_GCALL_READ] |
         (ENGINE.cmd_write & ENGINE.gcall_sent &
         ENGINE.cmd_word[i2c_esa_pkg::CMD_GCALL_READ_BIT]);
   end

   // Any cause at all counts as a transmit-abort event.
   logic abort_evt;
   assign abort_evt = |cause_set;

   ////////////////////////////////////////////////////////////////////
   // Abort-cause register and transmit-abort flag.
   // The cause bits, the flushed-entry count and the flag share one clear.
   // A cause that arrives in the same cycle as the clearing read wins, so an
   // abort that races software is never lost and shows on the next read.

   logic [i2c_esa_pkg::CA_HI:i2c_esa_pkg::CA_LO] cause_reg;
   logic [7:0] flush_reg;
   logic [i2c_esa_pkg::LEVEL_W-1:0] tx_level_prev_reg;
   logic tx_abort_reg;
   logic tx_abort_clr;

   // Reading the transmit-abort clear register is the only way to clear.
   assign tx_abort_clr = rd_done && PADDR == i2c_esa_pkg::OFS_TX_ABORT_CLR;

   // The level is delayed one cycle so the snapshot predates the event
   // even when the abort itself flushes the queue in that cycle.
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         tx_level_prev_reg <= '0;
      else
         tx_level_prev_reg <= ENGINE.tx_level;
   end

   // One process per bit keeps the set-wins-over-clear rule plain to read.
   // engine-reported and locally derived causes kept
   genvar b;
   generate
      for (b = i2c_esa_pkg::CA_LO; b <= i2c_esa_pkg::CA_HI; b++)
      begin : g_cause
         always_ff @(posedge CLK or negedge RESET_N)
         begin
            if (!RESET_N)
               cause_reg[b] <= 1'b0;
            else if (cause_set[b])
               cause_reg[b] <= 1'b1;
            else if (tx_abort_clr)
               cause_reg[b] <= 1'b0;
         end
      end
   endgenerate

   // The count is widened to the eight-bit field with zeros above the level.
   // level snapshot at abort
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         flush_reg <= 8'h00;
      else if (abort_evt)
         flush_reg <= {{(8 - i2c_esa_pkg::LEVEL_W){1'b0}}, tx_level_prev_reg};
      else if (tx_abort_clr)
         flush_reg <= 8'h00;
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         tx_abort_reg <= 1'b0;
      else if (abort_evt)
         tx_abort_reg <= 1'b1;
      else if (tx_abort_clr)
         tx_abort_reg <= 1'b0;
   end

   // The flag goes straight out as the raw transmit-abort interrupt.
   assign TRANSMIT_ABORT_IRQ = tx_abort_reg;

   ////////////////////////////////////////////////////////////////////
   // General-call flag.
   // The flag is sticky until software reads the clear register. As with the
   // abort flag, a new event in the clearing cycle keeps the flag set.

   logic general_call_irq_reg;

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         general_call_irq_reg <= 1'b0;
      else if (ENGINE.general_call_irq_evt)
         general_call_irq_reg <= 1'b1;
      else if (rd_done && PADDR == i2c_esa_pkg::OFS_GENERAL_CALL_IRQ_CLR)
         general_call_irq_reg <= 1'b0;
   end

   // The flag goes straight out as the raw general-call interrupt.
   assign GENERAL_CALL_IRQ = general_call_irq_reg;

   ////////////////////////////////////////////////////////////////////
   // Status word.
   // The status bits are pure functions of what the engine reports this cycle.
   // Full is judged against the queue depths given as parameters, empty against zero;
   // a depth above fifteen would not fit the four-bit level and is unsupported.

   logic [6:0] status_word;

   // Each bit follows its source combinationally.
   always_comb
   begin
      status_word = '0;
      status_word[i2c_esa_pkg::ST_TARG_BUSY] = ENGINE.targ_busy;
      status_word[i2c_esa_pkg::ST_INIT_BUSY] = ENGINE.init_busy;
      status_word[i2c_esa_pkg::ST_RX_FULL] =
         ENGINE.rx_level == i2c_esa_pkg::LEVEL_W'(RX_DEPTH);
      status_word[i2c_esa_pkg::ST_RX_NONEMPTY] = ENGINE.rx_level != '0;
      status_word[i2c_esa_pkg::ST_TX_EMPTY] = ENGINE.tx_level == '0;
      status_word[i2c_esa_pkg::ST_TX_NOT_FULL] =
         ENGINE.tx_level != i2c_esa_pkg::LEVEL_W'(TX_DEPTH);
      status_word[i2c_esa_pkg::ST_ACTIVITY] = ENGINE.targ_busy | ENGINE.init_busy |
         ENGINE.bus_active;
   end

   ////////////////////////////////////////////////////////////////////
   // Read data, captured in the setup cycle.

   // Pick the addressed register; unmapped and clear offsets read as zero.
   always_comb
   begin
      read_mux = '0;
      case (PADDR)
         i2c_esa_pkg::OFS_ENABLE:
         begin
            read_mux[i2c_esa_pkg::EN_BIT] = enable_reg;
            read_mux[i2c_esa_pkg::ABORT_BIT] = ABORT_REQUEST;
         end
         i2c_esa_pkg::OFS_STATUS: read_mux[6:0] = status_word;
         i2c_esa_pkg::OFS_TX_LEVEL: read_mux[i2c_esa_pkg::LEVEL_W-1:0] = ENGINE.tx_level;
         i2c_esa_pkg::OFS_RX_LEVEL: read_mux[i2c_esa_pkg::LEVEL_W-1:0] = ENGINE.rx_level;
         i2c_esa_pkg::OFS_HOLD: read_mux[15:0] = hold_reg;
         i2c_esa_pkg::OFS_ABORT_CAUSE:
         begin
            read_mux[i2c_esa_pkg::CA_HI:i2c_esa_pkg::CA_LO] = cause_reg;
            read_mux[31:i2c_esa_pkg::FLUSH_LSB] = flush_reg;
         end
         default: read_mux = '0;
      endcase
   end

   // Clear registers read as zero; their effect is the clear itself.
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         PRDATA <= 32'h00000000;
      else if (setup_phase && !PWRITE)
         PRDATA <= read_mux;
   end

endmodule : i2c_esa_regs

// *** i2c_esa_regs_chk.sv ***
/* Checker on the top ports of the register slice.
   Assumes one clock domain and a zero-wait APB slave. */
`timescale 1ns/100ps
module i2c_esa_regs_chk
#(
   parameter int TX_DEPTH = 8,
   parameter int RX_DEPTH = 8
)
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire i2c_esa_pkg::engine_status_t ENGINE,
   input wire logic CONTROLLER_ON,
   input wire logic ABORT_REQUEST,
   input wire logic [15:0] DATA_LINE_HOLD_CYCLES,
   input wire logic GENERAL_CALL_IRQ,
   input wire logic TRANSMIT_ABORT_IRQ
);
   logic wr;
   logic rd;
   logic [6:0] st_exp;
   // Completed transfers, and the status word that the engine levels call for.
   assign wr = PSEL && PENABLE && PWRITE;
   assign rd = PSEL && PENABLE && !PWRITE;
   assign st_exp = {ENGINE.targ_busy, ENGINE.init_busy, ENGINE.rx_level == RX_DEPTH[3:0],
      ENGINE.rx_level != 4'h0, ENGINE.tx_level == 4'h0, ENGINE.tx_level != TX_DEPTH[3:0],
      ENGINE.targ_busy || ENGINE.init_busy || ENGINE.bus_active};
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   ////////////////////////////////////////////////////////////////////
   enable_write_a: assert property (
      wr && PADDR == 8'h6C |=> CONTROLLER_ON == $past(PWDATA[0]))
      else $error("enable bit differs from write");
   abort_start_a: assert property (
      wr && PADDR == 8'h6C && PWDATA[1] |=> ABORT_REQUEST)
      else $error("abort did not start");
   abort_end_a: assert property (
      ABORT_REQUEST && ENGINE.abort_done |=> !ABORT_REQUEST && TRANSMIT_ABORT_IRQ)
      else $error("abort end not recorded");
   gcall_set_a: assert property (
      ENGINE.general_call_irq_evt |=> GENERAL_CALL_IRQ)
      else $error("general call flag not set");
   gcall_clear_a: assert property (
      rd && PADDR == 8'h68 && !ENGINE.general_call_irq_evt |=> !GENERAL_CALL_IRQ)
      else $error("general call flag not cleared");
   abort_clear_a: assert property (
      rd && PADDR == 8'h54 && ENGINE.cause_evt == '0 && !ENGINE.abort_done |=> !TRANSMIT_ABORT_IRQ)
      else $error("abort flag not cleared");
   status_read_a: assert property (
      PSEL && !PENABLE && !PWRITE && PADDR == 8'h70 |=> PRDATA == {25'h0, $past(st_exp)})
      else $error("status word wrong");
   hold_write_a: assert property (
      wr && PADDR == 8'h7C |=> DATA_LINE_HOLD_CYCLES == $past(PWDATA[15:0]))
      else $error("hold time not taken");
   abort_seen_c: cover property (ABORT_REQUEST && ENGINE.abort_done);
   gcall_clr_c: cover property (rd && PADDR == 8'h68 && GENERAL_CALL_IRQ);
   status_c: cover property (rd && PADDR == 8'h70);
endmodule : i2c_esa_regs_chk

bind i2c_esa_regs i2c_esa_regs_chk #(.TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH)) u_chk (.*);

// *** i2c_esa_engine_model.sv ***
/* Engine stand-in: passes the bench's levels and pulses, and ends aborts.
   Assumes the bench never pulses abort completion itself. */
`timescale 1ns/100ps
module i2c_esa_engine_model
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic abort_request,
   input wire logic [3:0] done_delay,
   input wire i2c_esa_pkg::engine_status_t cmd,
   output i2c_esa_pkg::engine_status_t engine
);
   logic [4:0] wait_reg;
   // abort completion
   // Winding down takes bus time, so completion comes done_delay cycles late.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         wait_reg <= 5'h00;
      else if (!abort_request)
         wait_reg <= 5'h00;
      else if (wait_reg <= {1'b0, done_delay})
         wait_reg <= wait_reg + 5'h01;
   end
   // Levels pass through; completion pulses once per abort.
   always_comb
   begin
      engine = cmd;
      engine.abort_done = abort_request && wait_reg == {1'b0, done_delay};
   end
endmodule : i2c_esa_engine_model

// *** tb_top.sv ***
/* Self-checking bench for the register slice with an engine model.
   Assumes the package, design, model and checker are compiled first. */
`timescale 1ns/100ps
module tb_top;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] delay = 4'h0;
   i2c_esa_pkg::engine_status_t cmd = '0;
   i2c_esa_pkg::engine_status_t eng;
   logic pready, pslverr, err, ctl_on, abort_req, gc_irq, ta_irq;
   logic [31:0] prdata, rd;
   logic [15:0] hold;
   int bad_count = 0;
   int n_checks = 0;
   localparam logic [7:0] RST_ADDR [6] = '{8'h6C, 8'h70, 8'h74, 8'h78, 8'h7C, 8'h80};
   localparam logic [31:0] RST_VAL [6] = '{32'h0, 32'h6, 32'h0, 32'h0, 32'h1, 32'h0};

   i2c_esa_regs dut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .ENGINE(eng), .CONTROLLER_ON(ctl_on), .ABORT_REQUEST(abort_req),
      .DATA_LINE_HOLD_CYCLES(hold), .GENERAL_CALL_IRQ(gc_irq), .TRANSMIT_ABORT_IRQ(ta_irq));
   i2c_esa_engine_model partner (.clk(clk), .reset_n(reset_n), .abort_request(abort_req),
      .done_delay(delay), .cmd(cmd), .engine(eng));

   // A 200 MHz clock.
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; the request is held until pready is seen high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task report_and_stop;
      $display("checks %0d bad %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////
   // reset and writes
   task t_regs;
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b0, RST_ADDR[i], 32'h0);
         chk(rd, RST_VAL[i]);
      end
      apb(1'b1, 8'h6C, 32'h1);
      apb(1'b1, 8'h7C, 32'hFFFFFFFF);
      apb(1'b1, 8'h20, 32'h1);
      chk({14'h0, ctl_on, hold, err}, 32'h0003FFFF);
   endtask : t_regs
   task st(input logic [2:0] bz, input logic [3:0] tx, input logic [3:0] rx, input logic [31:0] e);
      cmd <= '{targ_busy: bz[2], init_busy: bz[1], bus_active: bz[0], tx_level: tx,
         rx_level: rx, default: 0};
      @(posedge clk);
      apb(1'b0, 8'h70, 32'h0);
      chk(rd, e);
      apb(1'b0, 8'h78, 32'h0);
      chk(rd, {28'h0, rx});
      apb(1'b0, 8'h74, 32'h0);
      chk(rd, {28'h0, tx});
   endtask : st
   task t_abort(input logic [3:0] dly);
      cmd <= '{tx_level: 4'h5, default: 0};
      delay <= dly;
      apb(1'b1, 8'h6C, 32'h3);
      apb(1'b0, 8'h6C, 32'h0);
      chk(rd, {30'h0, dly != 4'h0, 1'b1});
      for (int n = 0; n < 20 && abort_req !== 1'b0; n++)
         @(posedge clk);
      apb(1'b0, 8'h80, 32'h0);
      chk({rd[31:1], ta_irq}, 32'h05010001);
      apb(1'b0, 8'h54, 32'h0);
      apb(1'b0, 8'h80, 32'h0);
      chk({rd[31:1], ta_irq}, 32'h0);
   endtask : t_abort
   task cause(input i2c_esa_pkg::engine_status_t p, input logic [31:0] e);
      cmd <= cmd | p;
      @(posedge clk);
      cmd <= cmd & ~p;
      apb(1'b0, 8'h80, 32'h0);
      chk({rd[31:1], ta_irq}, e | 32'(e != 32'h0));
      apb(1'b0, 8'h54, 32'h0);
   endtask : cause
   task t_causes;
      cmd <= '{tx_level: 4'h2, default: 0};
      @(posedge clk);
      for (int b = 2; b <= 16; b++)
         cause('{cause_evt: 15'h1 << (b - 2), default: 0},
            32'h02000000 | (32'h1 << b) | ((b == 14) ? 32'h1000 : 32'h0));
      cause('{targ_read_cmd: 1, default: 0}, 32'h02002000);
      cause('{init_start_req: 1, default: 0}, 32'h02000800);
      cause('{tenbit_read_req: 1, default: 0}, 32'h02000400);
      cause('{start_byte_req: 1, default: 0}, 32'h02000200);
      cause('{highspeed_req: 1, default: 0}, 32'h02000100);
      cause('{highspeed_req: 1, restart_allow: 1, default: 0}, 32'h0);
      cause('{cmd_write: 1, targ_rd_pending: 1, cmd_word: 10'h100, default: 0},
         32'h02008000);
      cause('{cmd_write: 1, gcall_sent: 1, cmd_word: 10'h200, default: 0},
         32'h02000020);
   endtask : t_causes
   task t_gcall;
      cmd <= '{general_call_irq_evt: 1, default: 0};
      @(posedge clk);
      cmd <= '0;
      @(posedge clk);
      chk({31'h0, gc_irq}, 32'h1);
      apb(1'b0, 8'h68, 32'h0);
      chk({rd[31:1], gc_irq}, 32'h0);
   endtask : t_gcall
   task t_reset;
      cmd <= '{general_call_irq_evt: 1, default: 0};
      @(posedge clk);
      cmd <= '0;
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk({12'h0, ctl_on, hold, gc_irq, ta_irq, abort_req}, {12'h0, 1'b0, 16'h0001, 3'b000});
      reset_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, 8'h70, 32'h0);
      chk(rd, 32'h6);
   endtask : t_reset
   ////////////////////////////////////////////////////////////////////
   // Main sequence after 20 cycles of reset.
   initial
   begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_regs();
      st(3'b100, 4'h8, 4'h8, 32'h59);
      st(3'b010, 4'h3, 4'h0, 32'h23);
      st(3'b001, 4'h0, 4'h1, 32'h0F);
      st(3'b000, 4'h7, 4'h7, 32'h0A);
      t_abort(4'h0);
      t_abort(4'h7);
      t_causes();
      t_gcall();
      t_reset();
      report_and_stop();
   end
   // Hang guard, far beyond the few hundred cycles the run needs.
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end
endmodule : tb_top
